// File: hdl/tdi_pkg.sv
// constants, state codes and address helpers for the time de-interleaver
package tdi_pkg;
    localparam int MAX_CODED_BLOCKS_PER_FRAME = 1;
    localparam int INTERLEAVE_BLOCKS_PER_FRAME = 1;
    // memory sized for the largest coded-block count per block
    localparam int N_MAX = (MAX_CODED_BLOCKS_PER_FRAME
        + INTERLEAVE_BLOCKS_PER_FRAME - 1) / INTERLEAVE_BLOCKS_PER_FRAME;
    localparam int COLS_PER_BLOCK = 5;
    localparam int COLS = COLS_PER_BLOCK * N_MAX;
    localparam int ROWS = 8;
    localparam int MEM_CELLS = ROWS * COLS;
    localparam int CELLS_PER_BLOCK = MEM_CELLS / N_MAX;
    localparam int ADDR_W = $clog2(MEM_CELLS);
    localparam int NB_W = $clog2(N_MAX + 1);
    localparam int CELL_W = 24;
    localparam int FIFO_DEPTH = 4000;
    localparam int FIFO_AW = 12;
    localparam int FIFO_CW = 12;
    localparam logic [ADDR_W-1:0] LAST_POS = ADDR_W'(MEM_CELLS - 1);
    localparam logic [ADDR_W-1:0] CAPTURE_POS = ADDR_W'(COLS);
    localparam logic [ADDR_W-1:0] ADDR_RESET = '0;
    localparam logic [ADDR_W-1:0] INCR_RESET = ADDR_W'(1);
    localparam logic [FIFO_AW-1:0] FIFO_LAST = FIFO_AW'(FIFO_DEPTH - 1);
    localparam logic [FIFO_CW-1:0] FIFO_FULL = FIFO_CW'(FIFO_DEPTH);
    localparam logic [FIFO_CW-1:0] FIFO_ROOM2 = FIFO_CW'(FIFO_DEPTH - 2);

    typedef enum logic [3:0] {
        ST_WAIT = 4'h1,
        ST_FILL = 4'h2,
        ST_RUN = 4'h4,
        ST_TAIL = 4'h8
    } tdi_state_t;

    function automatic logic [ADDR_W-1:0] tdi_step(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] k);
        if (a <= LAST_POS - k)
            return a + k;
        else
            return a - (LAST_POS - k);
    endfunction

    function automatic logic [ADDR_W-1:0] tdi_knext(
        input logic [ADDR_W-1:0] k);
        int t;
        t = (int'(k) * COLS) % MEM_CELLS + int'(k) / ROWS;
        return t[ADDR_W-1:0];
    endfunction

    function automatic int tdi_unused(input logic [NB_W-1:0] nwr);
        int n;
        n = (int'(nwr) > N_MAX) ? N_MAX : int'(nwr);
        return N_MAX - n;
    endfunction

    function automatic logic tdi_skip(
        input logic [ADDR_W-1:0] pos,
        input logic [NB_W-1:0] nwr);
        int col;
        col = int'(pos) % COLS;
        return col < COLS_PER_BLOCK * tdi_unused(nwr);
    endfunction

    function automatic int tdi_head(input logic [NB_W-1:0] nwr);
        return CELLS_PER_BLOCK * tdi_unused(nwr);
    endfunction
endpackage

// File: hdl/tdi_deinterleaver.sv
// single-memory time de-interleaver with output cell fifo
//
// Function
// - after the first block, read each cell then write the input there
// - memory holds rows times columns cells, one linear block
// - first block only stores cells sequentially, no output
// - address starts at zero, adds k or subtracts M-k-1 on wrap
// - increment starts at one, next is (k*c) mod M plus k div r
// - address cleared at block start, advances modulo M minus one
// - next increment captured from address of cell c+1
// - eight by five setup cycles increment back to one in four blocks
// - memory sized for maximum coded blocks per interleaving block
// - writer skips 5 times unused blocks positions at each row start
// - reader skips nothing, starts late by cells of unused blocks
// - a 4000-cell fifo goes with the de-interleaver
// - with interleaving disabled read and write use plain order
`timescale 1ns/10ps
`default_nettype none
module tdi_deinterleaver (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic cell_valid_in,
    input wire logic [tdi_pkg::CELL_W-1:0] cell_data_in,
    input wire logic block_start_in,
    input wire logic [tdi_pkg::NB_W-1:0] coded_blocks_in,
    input wire logic ti_enable_in,
    input wire logic out_ready_in,
    output logic cell_ready_out,
    output logic out_valid_out,
    output logic [tdi_pkg::CELL_W-1:0] out_cell_out,
    output logic [tdi_pkg::ADDR_W-1:0] incr_out
);
    localparam int AW = tdi_pkg::ADDR_W;
    localparam int CW = tdi_pkg::FIFO_CW;
    localparam int PW = tdi_pkg::FIFO_AW;

    // one block of cells only; a second block never has to be held
    logic [tdi_pkg::CELL_W-1:0] mem [tdi_pkg::MEM_CELLS];
    logic [tdi_pkg::CELL_W-1:0] fifo_mem [tdi_pkg::FIFO_DEPTH];

    tdi_pkg::tdi_state_t state_r, state_nxt;
    logic [AW-1:0] pos_r, pos_nxt;
    logic [AW-1:0] addr_r, addr_nxt;
    logic [AW-1:0] incr_r, incr_nxt;
    logic [AW-1:0] cap_r, cap_nxt;
    logic [tdi_pkg::NB_W-1:0] nwr_wr_r, nwr_wr_nxt;
    logic [tdi_pkg::NB_W-1:0] nwr_rd_r, nwr_rd_nxt;
    logic ti_en_r, ti_en_nxt;
    logic ready_r, ready_nxt;
    logic [PW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [PW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic out_valid_r, out_valid_nxt;
    logic [tdi_pkg::CELL_W-1:0] out_cell_r;

    logic in_blk;
    logic need_in;
    logic rd;
    logic acc;
    logic step;
    logic push;
    logic pop;
    logic start;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == tdi_pkg::FIFO_LAST) ? '0 : p + 1'b1;
    endfunction

    // sequencing of positions through the block
    always_comb
    begin
        in_blk = (state_r == tdi_pkg::ST_FILL) || (state_r == tdi_pkg::ST_RUN);
        need_in = in_blk && !tdi_pkg::tdi_skip(pos_r, nwr_wr_r);
        rd = (state_r == tdi_pkg::ST_RUN)
            && int'(pos_r) >= tdi_pkg::tdi_head(nwr_rd_r);
        acc = cell_valid_in && ready_r;
        // a skipped write position steps without an input cell
        step = in_blk && (need_in ? acc
            : (!rd || cnt_r < tdi_pkg::FIFO_FULL));
        push = step && rd;
        pop = (cnt_r != '0) && (!out_valid_r || out_ready_in);
        // start is seen with valid but the cell waits for ready
        start = ((state_r == tdi_pkg::ST_WAIT)
            || (state_r == tdi_pkg::ST_TAIL))
            && cell_valid_in && block_start_in;

        state_nxt = state_r;
        pos_nxt = pos_r;
        addr_nxt = addr_r;
        incr_nxt = incr_r;
        cap_nxt = cap_r;
        nwr_wr_nxt = nwr_wr_r;
        nwr_rd_nxt = nwr_rd_r;
        ti_en_nxt = ti_en_r;
        if (start)
        begin
            state_nxt = (state_r == tdi_pkg::ST_WAIT) ? tdi_pkg::ST_FILL
                : tdi_pkg::ST_RUN;
            pos_nxt = '0;
            addr_nxt = tdi_pkg::ADDR_RESET;
            nwr_wr_nxt = coded_blocks_in;
            nwr_rd_nxt = nwr_wr_r;
            ti_en_nxt = ti_enable_in;
            // disabled mode walks plain order for read and write
            incr_nxt = ti_enable_in ? incr_r : tdi_pkg::INCR_RESET;
        end
        else if (step)
        begin
            if (pos_r == tdi_pkg::CAPTURE_POS)
                cap_nxt = addr_r;
            if (pos_r == tdi_pkg::LAST_POS)
            begin
                state_nxt = tdi_pkg::ST_TAIL;
                pos_nxt = '0;
                addr_nxt = tdi_pkg::ADDR_RESET;
                // captured address equals (k*c) mod M + k div r
                incr_nxt = ti_en_r ? cap_r : tdi_pkg::INCR_RESET;
            end
            else
            begin
                pos_nxt = pos_r + 1'b1;
                addr_nxt = tdi_pkg::tdi_step(addr_r, incr_r);
            end
        end

        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        wr_ptr_nxt = push ? ptr_inc(wr_ptr_r) : wr_ptr_r;
        rd_ptr_nxt = pop ? ptr_inc(rd_ptr_r) : rd_ptr_r;
        if (pop)
            out_valid_nxt = 1'b1;
        else if (out_ready_in)
            out_valid_nxt = 1'b0;
        else
            out_valid_nxt = out_valid_r;

        // registered ready: keep room for the one cell it may let in
        ready_nxt = ((state_nxt == tdi_pkg::ST_FILL)
            || (state_nxt == tdi_pkg::ST_RUN))
            && !tdi_pkg::tdi_skip(pos_nxt, nwr_wr_nxt)
            && (cnt_nxt <= tdi_pkg::FIFO_ROOM2);
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_r <= tdi_pkg::ST_WAIT;
            pos_r <= '0;
            addr_r <= tdi_pkg::ADDR_RESET;
            incr_r <= tdi_pkg::INCR_RESET;
            cap_r <= tdi_pkg::INCR_RESET;
            nwr_wr_r <= '0;
            nwr_rd_r <= '0;
            ti_en_r <= 1'b0;
            ready_r <= 1'b0;
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            out_valid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pos_r <= pos_nxt;
            addr_r <= addr_nxt;
            incr_r <= incr_nxt;
            cap_r <= cap_nxt;
            nwr_wr_r <= nwr_wr_nxt;
            nwr_rd_r <= nwr_rd_nxt;
            ti_en_r <= ti_en_nxt;
            ready_r <= ready_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    // memories carry no reset; old cell leaves before the new one lands
    always_ff @(posedge clock_in)
    begin
        if (push)
            fifo_mem[wr_ptr_r] <= mem[addr_r];
        if (acc)
            mem[addr_r] <= cell_data_in;
        if (pop)
            out_cell_r <= fifo_mem[rd_ptr_r];
    end

    assign cell_ready_out = ready_r;
    assign out_valid_out = out_valid_r;
    assign out_cell_out = out_cell_r;
    assign incr_out = incr_r;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    sequence s_blk_end;
        step && pos_r == tdi_pkg::LAST_POS;
    endsequence

    sequence s_fresh;
        pos_r == '0 && addr_r == tdi_pkg::ADDR_RESET;
    endsequence

    property p_start;
        start |=> s_fresh ##0 in_blk;
    endproperty
    a_start: assert property (p_start)
        else $error("block start did not clear the address");

    property p_wrap;
        s_blk_end |=> s_fresh ##0 (state_r == tdi_pkg::ST_TAIL);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("address not cleared at block end");

    property p_step;
        step && pos_r != tdi_pkg::LAST_POS |=>
            addr_r == tdi_pkg::tdi_step($past(addr_r), $past(incr_r));
    endproperty
    a_step: assert property (p_step)
        else $error("address step wrong");

    property p_knext;
        s_blk_end and ti_en_r |=>
            incr_r == tdi_pkg::tdi_knext($past(incr_r));
    endproperty
    a_knext: assert property (p_knext)
        else $error("next block increment wrong");

    property p_fill;
        state_r == tdi_pkg::ST_FILL |-> !push && !out_valid_r;
    endproperty
    a_fill: assert property (p_fill)
        else $error("output during first block");

    property p_rdwr;
        acc && state_r == tdi_pkg::ST_RUN && rd |-> push;
    endproperty
    a_rdwr: assert property (p_rdwr)
        else $error("write without read in running block");

    property p_range;
        addr_r <= tdi_pkg::LAST_POS && pos_r <= tdi_pkg::LAST_POS;
    endproperty
    a_range: assert property (p_range)
        else $error("address out of memory");

    property p_skip;
        acc |-> !tdi_pkg::tdi_skip(pos_r, nwr_wr_r);
    endproperty
    a_skip: assert property (p_skip)
        else $error("cell written in unused column");

    property p_head;
        push |-> int'(pos_r) >= tdi_pkg::tdi_head(nwr_rd_r);
    endproperty
    a_head: assert property (p_head)
        else $error("read before head start");

    property p_plain;
        in_blk && !ti_en_r |-> incr_r == tdi_pkg::INCR_RESET;
    endproperty
    a_plain: assert property (p_plain)
        else $error("disabled mode not in plain order");

    property p_fifo;
        push && !pop |=> cnt_r == $past(cnt_r) + 1'b1
            && cnt_r <= tdi_pkg::FIFO_FULL;
    endproperty
    a_fifo: assert property (p_fifo)
        else $error("fifo count wrong");

    property p_first_k;
        s_blk_end and (state_r == tdi_pkg::ST_FILL && ti_en_r) |=>
            int'(incr_r) == tdi_pkg::COLS;
    endproperty
    a_first_k: assert property (p_first_k)
        else $error("first read block not stepping by columns");

    property p_cap;
        step && pos_r == tdi_pkg::CAPTURE_POS |=> cap_r == $past(addr_r);
    endproperty
    a_cap: assert property (p_cap)
        else $error("increment not captured");

    property p_hold;
        out_valid_r && !out_ready_in |=> out_valid_r && $stable(out_cell_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output cell dropped before taken");

    property p_idle;
        state_r == tdi_pkg::ST_WAIT || state_r == tdi_pkg::ST_TAIL
            |-> !ready_r;
    endproperty
    a_idle: assert property (p_idle)
        else $error("cell accepted outside a block");
endmodule
`default_nettype wire

// File: sim/tdi_stream_partner.sv
// upstream cell source and downstream sink around the de-interleaver
`timescale 1ns/10ps
`default_nettype none
module tdi_stream_partner #(
    parameter int NBLK = 7
) (
    input wire logic clock_in,
    input wire logic go_in,
    input wire logic [7:0] en_mask_in,
    input wire logic cell_ready_in,
    output logic cell_valid_out,
    output logic [tdi_pkg::CELL_W-1:0] cell_data_out,
    output logic block_start_out,
    output logic ti_enable_out,
    output logic out_ready_out,
    output logic done_out
);
    int seed = 32'hFD152F77;
    int n;
    logic acc;

    initial
    begin
        cell_valid_out = 1'b0;
        cell_data_out = '0;
        block_start_out = 1'b0;
        ti_enable_out = 1'b1;
        out_ready_out = 1'b0;
        done_out = 1'b0;
        while (!go_in)
            @(posedge clock_in);
        // whole blocks only, one written while one is read
        for (int b = 0; b < NBLK; b++)
        begin
            for (int i = 0; i < 40; i++)
            begin
                #1;
                cell_valid_out = 1'b1;
                cell_data_out = tdi_pkg::CELL_W'($random(seed));
                block_start_out = (i == 0);
                ti_enable_out = en_mask_in[b];
                acc = 1'b0;
                n = 0;
                // ready is registered, so mid-cycle equals the edge value
                while (!acc && n < 5000)
                begin
                    @(negedge clock_in);
                    acc = cell_ready_in;
                    @(posedge clock_in);
                    n++;
                end
                if ($random(seed) % 4 == 0)
                begin
                    #1;
                    cell_valid_out = 1'b0;
                    @(posedge clock_in);
                end
            end
        end
        #1;
        cell_valid_out = 1'b0;
        block_start_out = 1'b0;
        done_out = 1'b1;
    end

    always @(posedge clock_in)
    begin
        #1;
        out_ready_out = ($random(seed) % 4) != 0;
    end
endmodule
`default_nettype wire

// File: sim/time_deinterleave_addr_gen_tb_top.sv
// self-checking bench for the time de-interleaver
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, ac) begin checks++; if ((ex) !== (ac)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, ac); end end
module time_deinterleave_addr_gen_tb_top;
    localparam int NBLK = 7;
    localparam int M = tdi_pkg::ROWS * tdi_pkg::COLS;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic go = 1'b0;
    logic cell_valid, block_start, ti_enable, out_ready;
    logic cell_ready, out_valid, done;
    logic [tdi_pkg::CELL_W-1:0] cell_data, out_cell;
    logic [tdi_pkg::ADDR_W-1:0] incr;
    // full block count, so the writer never skips
    logic [tdi_pkg::NB_W-1:0] nwr = '1;
    logic [tdi_pkg::CELL_W-1:0] mem [M];
    logic [tdi_pkg::CELL_W-1:0] expq [$];
    int failures = 0;
    int checks = 0;
    int blk = -1;
    int idx = 0;
    int k = 1;
    logic en_prev = 1'b0;
    int a = 0;
    int got = 0;

    function automatic int next_k(input int kp);
        return (kp * tdi_pkg::COLS) % M + kp / tdi_pkg::ROWS;
    endfunction

    function automatic int step(input int ap, input int kk);
        return (ap < M - kk) ? ap + kk : ap - (M - kk - 1);
    endfunction

    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    tdi_deinterleaver uut (.clock_in(clock_in), .rst_in(rst_in),
        .cell_valid_in(cell_valid), .cell_data_in(cell_data),
        .block_start_in(block_start), .coded_blocks_in(nwr),
        .ti_enable_in(ti_enable), .out_ready_in(out_ready),
        .cell_ready_out(cell_ready), .out_valid_out(out_valid),
        .out_cell_out(out_cell), .incr_out(incr));

    tdi_stream_partner #(.NBLK(NBLK)) far (.clock_in(clock_in), .go_in(go),
        .en_mask_in(8'h5F), .cell_ready_in(cell_ready),
        .cell_valid_out(cell_valid), .cell_data_out(cell_data),
        .block_start_out(block_start), .ti_enable_out(ti_enable),
        .out_ready_out(out_ready), .done_out(done));

    always #5 clock_in = ~clock_in;

    always @(posedge clock_in)
    begin
        if (!rst_in && cell_valid && cell_ready)
        begin
            if (block_start)
            begin
                blk++;
                idx = 0;
                a = 0;
                // a block after a disabled one restarts like the first fill
                k = (blk > 0 && ti_enable && en_prev) ? next_k(k) : 1;
                en_prev = ti_enable;
            end
            else
                a = step(a, k);
            if (blk > 0)
                expq.push_back(mem[a]);
            else
                `CHK("fill_quiet", 1'b0, out_valid)
            mem[a] = cell_data;
            if (idx == 10)
                `CHK("incr", k[tdi_pkg::ADDR_W-1:0], incr)
            if (idx == 10 && blk == 4)
                `CHK("k_return", tdi_pkg::INCR_RESET, incr)
            idx++;
        end
        if (!rst_in && out_valid && out_ready)
        begin
            got++;
            if (expq.size() == 0)
                `CHK("extra_out", 1'b0, 1'b1)
            else
                `CHK("out_cell", expq.pop_front(), out_cell)
        end
    end

    initial
    begin
        repeat (20) @(posedge clock_in);
        #1;
        rst_in = 1'b0;
        `CHK("rst_ready", 1'b0, cell_ready)
        `CHK("rst_valid", 1'b0, out_valid)
        `CHK("rst_incr", tdi_pkg::INCR_RESET, incr)
        $display("test reset done");
        go = 1'b1;
        for (int n = 0; n < 20000 && !(done && got == 40 * (NBLK - 1)); n++)
            @(posedge clock_in);
        if (!(done && got == 40 * (NBLK - 1)))
        begin
            failures++;
            $display("ERROR stream_end expected %0d seen %0d",
                40 * (NBLK - 1), got);
        end
        $display("test stream done blocks %0d outputs %0d", blk + 1, got);
        end_of_test();
    end
endmodule
`default_nettype wire
